// File: design/pcr_parts.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // occupancy
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];
    assign level = count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_count = count;
        if (flush)
        begin
            next_wptr = '0;
            next_rptr = '0;
            next_count = '0;
        end
        else
        begin
            if (push)
            begin
                next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop)
            begin
                next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // storage needs no reset; only pointers and count decide what is valid
    always_ff @(posedge clk_sys)
    begin
        if (push && !flush)
        begin
            mem[wptr] <= in_data;
        end
    end
endmodule : pcr_fifo
`default_nettype wire

// File: design/pcr_pkg.sv
// Functional notes
// [RULE1] core reset input hard-resets whole core
// [RULE2] after release, training restarts without stimulus
// [RULE3] system asserts core reset for fundamental reset
// [RULE4] hot reset flagged on indicator, not core reset
// [RULE5] application reset on any reset or lock loss; hot reset here raises only hot_rst_rcvd, not user_rst
// [RULE6] application reset released synchronously, causes cleared
// [RULE7] endpoint wires sideband reset to core reset
// [RULE8] physical logic frames, trains, descrambles lane data
// [RULE9] lane polarity inversion and multi-lane reversal
// [RULE10] configuration reads and writes receive completions
// [RULE11] message interrupts and emulated legacy interrupts
// [RULE12] only default virtual channel is supported
// [RULE13] answer configuration requests once link active
// [RULE14] reference clock matches configured supported frequency
// [RULE15] reset causes pass two-flop synchroniser first
`default_nettype none
package pcr_pkg;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORD_W = LANES * LANE_W;
    localparam int SYNC_STAGES = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int VC_W = 3;
    localparam logic [VC_W-1:0] VC_DEFAULT = 3'h0;
    localparam int CLK_HZ = 10_000_000;
    localparam int HOT_HOLD_US = 2;
    // least time, so round up
    localparam int HOT_HOLD_CYC = (HOT_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int LFSR_W = 16;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hFFFF;
    localparam int TAP_A = 15;
    localparam int TAP_B = 4;
    localparam int TAP_C = 3;
    localparam int TAP_D = 2;

    typedef enum logic [4:0] {
        PCR_DETECT = 5'h01,
        PCR_POLL = 5'h02,
        PCR_CFG = 5'h04,
        PCR_L0 = 5'h08,
        PCR_HOTRST = 5'h10
    } pcr_link_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic last;
    } pcr_word_t;
endpackage : pcr_pkg
`default_nettype wire

// File: design/pcr_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_reset_ctrl #(
    parameter int LANES = pcr_pkg::LANES,
    parameter int DEPTH = pcr_pkg::FIFO_DEPTH,
    parameter int HOT_CYC = pcr_pkg::HOT_HOLD_CYC
) (
    // clock and reset; clk_sys doubles as the application clock
    input wire logic clk_sys,
    input wire logic nrst,
    // reset causes, asynchronous to clk_sys
    input wire logic core_rst,
    input wire logic wrap_pll_lock,
    input wire logic [LANES-1:0] xcvr_pll_lock,
    // physical layer status
    input wire logic rx_detected,
    input wire logic ts_locked,
    input wire logic hot_rst_os,
    input wire logic [LANES-1:0] lane_inv,
    input wire logic lane_rev,
    // received lane data
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [pcr_pkg::WORD_W-1:0] rx_data,
    input wire logic rx_end,
    // application stream
    output pcr_pkg::pcr_word_t user_word,
    output logic user_valid,
    input wire logic user_ready,
    // reset and link status
    output logic user_rst,
    output logic hot_rst_rcvd,
    output pcr_pkg::pcr_link_t link_state,
    output logic link_up,
    output logic [LANES-1:0] pol_inv,
    output logic lanes_reversed,
    // configuration requests
    input wire logic cfg_req,
    input wire logic cfg_rd,
    output logic cfg_cpl,
    output logic cfg_cpl_data,
    // interrupts toward the partner
    input wire logic app_intr,
    input wire logic msi_en,
    input wire logic intx_clr,
    output logic msi_msg,
    output logic intx_assert,
    // virtual channel select of a request
    input wire logic req_vc_valid,
    input wire logic [pcr_pkg::VC_W-1:0] req_vc,
    output logic vc_reject
);
    localparam int LW = pcr_pkg::LANE_W;
    localparam int WW = pcr_pkg::WORD_W;
    localparam int HW = $clog2(HOT_CYC + 1);

    // cause synchronisation
    logic core_rst_s, wrap_lock_s;
    logic [LANES-1:0] xcvr_lock_s;
    logic cause_any;

    // core reset comes up asserted so nothing escapes before the flops settle
    pcr_sync #(.W(1), .STAGES(pcr_pkg::SYNC_STAGES), .RST_VAL(1'b1)) u_sync_rst ( // RULE15
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d(core_rst),
        .q(core_rst_s)
    );

    pcr_sync #(.W(LANES + 1), .STAGES(pcr_pkg::SYNC_STAGES), .RST_VAL(1'b0)) u_sync_lock ( // RULE15
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d({wrap_pll_lock, xcvr_pll_lock}),
        .q({wrap_lock_s, xcvr_lock_s})
    );

    assign cause_any = core_rst_s || !wrap_lock_s || !(&xcvr_lock_s); // RULE5 RULE1

    // link state machine
    pcr_pkg::pcr_link_t state, next_state;
    logic [HW-1:0] hot_cnt, next_hot_cnt;
    logic [LANES-1:0] next_pol_inv;
    logic next_lanes_reversed, next_user_rst, next_hot_rst_rcvd, next_link_up;

    always_comb
    begin
        next_state = state;
        next_hot_cnt = '0;
        next_pol_inv = pol_inv;
        next_lanes_reversed = lanes_reversed;
        if (cause_any)
        begin
            next_state = pcr_pkg::PCR_DETECT; // RULE1
            next_pol_inv = '0;
            next_lanes_reversed = 1'b0;
        end
        else
        begin
            case (state)
                pcr_pkg::PCR_DETECT:
                begin
                    // training starts by itself once causes clear
                    if (rx_detected)
                    begin
                        next_state = pcr_pkg::PCR_POLL; // RULE2
                    end
                end
                pcr_pkg::PCR_POLL:
                begin
                    if (ts_locked)
                    begin
                        next_pol_inv = lane_inv; // RULE9
                        next_state = pcr_pkg::PCR_CFG; // RULE8
                    end
                end
                pcr_pkg::PCR_CFG:
                begin
                    if (!ts_locked)
                    begin
                        next_state = pcr_pkg::PCR_DETECT;
                    end
                    else
                    begin
                        // reversal has no meaning on a single lane
                        next_lanes_reversed = (LANES > 1) && lane_rev; // RULE9
                        next_state = pcr_pkg::PCR_L0; // RULE8
                    end
                end
                pcr_pkg::PCR_L0:
                begin
                    if (hot_rst_os)
                    begin
                        next_state = pcr_pkg::PCR_HOTRST; // RULE4
                    end
                    else if (!ts_locked)
                    begin
                        next_state = pcr_pkg::PCR_DETECT;
                    end
                end
                pcr_pkg::PCR_HOTRST:
                begin
                    // stay until the partner stops ordering it, then hold
                    if (hot_rst_os)
                    begin
                        next_hot_cnt = '0;
                    end
                    else if (hot_cnt >= HW'(HOT_CYC - 1))
                    begin
                        next_state = pcr_pkg::PCR_DETECT;
                    end
                    else
                    begin
                        next_hot_cnt = hot_cnt + 1'b1;
                    end
                end
                default:
                begin
                    next_state = pcr_pkg::PCR_DETECT;
                end
            endcase
        end
        // hot reset is reported only; core reset input stays out of it
        next_hot_rst_rcvd = (next_state == pcr_pkg::PCR_HOTRST); // RULE4
        next_link_up = (next_state == pcr_pkg::PCR_L0); // RULE13
        // release follows the clock edge after every cause is gone
        next_user_rst = cause_any; // RULE5 RULE6
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= pcr_pkg::PCR_DETECT;
            hot_cnt <= '0;
            pol_inv <= '0;
            lanes_reversed <= 1'b0;
            user_rst <= 1'b1;
            hot_rst_rcvd <= 1'b0;
            link_up <= 1'b0;
        end
        else
        begin
            state <= next_state;
            hot_cnt <= next_hot_cnt;
            pol_inv <= next_pol_inv;
            lanes_reversed <= next_lanes_reversed;
            user_rst <= next_user_rst; // RULE6
            hot_rst_rcvd <= next_hot_rst_rcvd;
            link_up <= next_link_up;
        end
    end

    assign link_state = state;

    // receive path: lane order, polarity, descramble
    logic [pcr_pkg::LFSR_W-1:0] lfsr, next_lfsr;
    logic [WW-1:0] lane_fixed;
    pcr_pkg::pcr_word_t fifo_in, fifo_out;
    logic fifo_push, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
    logic [$clog2(DEPTH):0] fifo_level;
    logic next_rx_ready;

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            localparam int SRC = LANES - 1 - g;
            logic [LW-1:0] picked;
            assign picked = lanes_reversed ? rx_data[SRC*LW +: LW] : rx_data[g*LW +: LW]; // RULE9
            assign lane_fixed[g*LW +: LW] = (picked ^ {LW{pol_inv[g]}}) ^ lfsr[LW-1:0]; // RULE9 RULE8
        end
    endgenerate

    assign fifo_push = rx_valid && rx_ready && fifo_in_ready && link_up;
    assign fifo_flush = !link_up;
    assign fifo_in.data = lane_fixed;
    assign fifo_in.last = rx_end;

    always_comb
    begin
        next_lfsr = lfsr;
        if (!link_up)
        begin
            next_lfsr = pcr_pkg::LFSR_SEED;
        end
        else if (fifo_push)
        begin
            next_lfsr = {lfsr[pcr_pkg::LFSR_W-2:0],
                lfsr[pcr_pkg::TAP_A] ^ lfsr[pcr_pkg::TAP_B] ^ lfsr[pcr_pkg::TAP_C] ^ lfsr[pcr_pkg::TAP_D]}; // RULE8
        end
        // two free slots cover the word in flight while ready is registered
        next_rx_ready = link_up && (fifo_level <= ($clog2(DEPTH)+1)'(DEPTH - 2));
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            lfsr <= pcr_pkg::LFSR_SEED;
            rx_ready <= 1'b0;
        end
        else
        begin
            lfsr <= next_lfsr;
            rx_ready <= next_rx_ready;
        end
    end

    pcr_fifo #(.W($bits(pcr_pkg::pcr_word_t)), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // output register so the stream leaves straight from flops
    pcr_pkg::pcr_word_t next_user_word;
    logic next_user_valid;

    assign fifo_pop = fifo_out_valid && (!user_valid || user_ready) && link_up;

    always_comb
    begin
        next_user_word = user_word;
        next_user_valid = user_valid;
        if (!link_up)
        begin
            next_user_valid = 1'b0;
        end
        else if (fifo_pop)
        begin
            next_user_word = fifo_out;
            next_user_valid = 1'b1;
        end
        else if (user_ready)
        begin
            next_user_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            user_word <= '0;
            user_valid <= 1'b0;
        end
        else
        begin
            user_word <= next_user_word;
            user_valid <= next_user_valid;
        end
    end

    // configuration, interrupts, channel check
    logic next_cfg_cpl, next_cfg_cpl_data, next_msi_msg, next_intx_assert, next_vc_reject;

    always_comb
    begin
        // without a link the request goes unanswered, as an absent device
        next_cfg_cpl = cfg_req && link_up; // RULE10 RULE13
        next_cfg_cpl_data = cfg_req && link_up && cfg_rd; // RULE10
        next_msi_msg = app_intr && msi_en && link_up; // RULE11
        next_intx_assert = intx_assert;
        // a new interrupt wins over a clear in the same cycle
        if (app_intr && !msi_en && link_up)
        begin
            next_intx_assert = 1'b1; // RULE11
        end
        else if (intx_clr || !link_up)
        begin
            next_intx_assert = 1'b0;
        end
        next_vc_reject = req_vc_valid && (req_vc != pcr_pkg::VC_DEFAULT); // RULE12
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_cpl <= 1'b0;
            cfg_cpl_data <= 1'b0;
            msi_msg <= 1'b0;
            intx_assert <= 1'b0;
            vc_reject <= 1'b0;
        end
        else
        begin
            cfg_cpl <= next_cfg_cpl;
            cfg_cpl_data <= next_cfg_cpl_data;
            msi_msg <= next_msi_msg;
            intx_assert <= next_intx_assert;
            vc_reject <= next_vc_reject;
        end
    end
endmodule : pcr_reset_ctrl
`default_nettype wire

// File: design/pcr_reset_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_sync #(
    parameter int W = 1,
    parameter int STAGES = 2,
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage [STAGES];
    logic [W-1:0] next_stage [STAGES];

    always_comb
    begin
        next_stage[0] = d;
        for (int i = 1; i < STAGES; i++)
        begin
            next_stage[i] = stage[i-1];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                stage[i] <= {W{RST_VAL}};
            end
        end
        else
        begin
            stage <= next_stage;
        end
    end

    assign q = stage[STAGES-1];
endmodule : pcr_sync
`default_nettype wire

// File: tb/pcr_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_link_partner (
    // clock
    input wire logic clk_sys,
    // bench control
    input wire logic train,
    input wire logic hot,
    // toward the core
    output logic rx_detected,
    output logic ts_locked,
    output logic hot_rst_os,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [pcr_pkg::WORD_W-1:0] rx_data,
    output logic rx_end
);
    initial
    begin
        {rx_detected, ts_locked, hot_rst_os, rx_valid, rx_end} = '0;
        rx_data = '0;
    end
    always @(negedge clk_sys)
    begin
        rx_detected <= train;
        ts_locked <= train;
        hot_rst_os <= hot;
    end
    task automatic send(input logic [pcr_pkg::WORD_W-1:0] w, input logic e, output logic took);
        int n;
        n = 0;
        @(negedge clk_sys);
        rx_valid = 1'b1;
        rx_data = w;
        rx_end = e;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (rx_ready !== 1'b1 && n < 500);
        // a word never taken is reported back instead of hanging the bench
        took = (rx_ready === 1'b1);
        @(negedge clk_sys);
        rx_valid = 1'b0;
        // released lines never repeat the last word
        rx_data = ~w;
        rx_end = ~e;
    endtask : send
endmodule : pcr_link_partner
`default_nettype wire

// File: tb/pcr_rc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_rc_props #(
    parameter int LANES = pcr_pkg::LANES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // reset causes
    input wire logic core_rst,
    input wire logic wrap_pll_lock,
    input wire logic [LANES-1:0] xcvr_pll_lock,
    // requests
    input wire logic cfg_req,
    input wire logic cfg_rd,
    input wire logic app_intr,
    input wire logic msi_en,
    input wire logic req_vc_valid,
    input wire logic [pcr_pkg::VC_W-1:0] req_vc,
    // answers
    input wire logic user_rst,
    input wire pcr_pkg::pcr_link_t link_state,
    input wire logic link_up,
    input wire logic cfg_cpl,
    input wire logic cfg_cpl_data,
    input wire logic msi_msg,
    input wire logic intx_assert,
    input wire logic vc_reject
);
    logic clr;
    assign clr = !core_rst && wrap_pll_lock && (&xcvr_pll_lock);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_core_rst_seen: assert property (core_rst |-> ##3 (user_rst && link_state == pcr_pkg::PCR_DETECT))
        else $error("no user reset after core reset");
    a_lock_loss: assert property (!(wrap_pll_lock && (&xcvr_pll_lock)) |-> ##3 user_rst)
        else $error("no user reset after lock loss");
    // a fall or rise must trace back through both synchroniser flops
    a_rst_release: assert property ($fell(user_rst) |-> $past(clr, 3))
        else $error("user reset released early");
    a_rst_rise: assert property ($rose(user_rst) |-> !$past(clr, 3))
        else $error("user reset raised without synchroniser");
    a_cfg_answer: assert property (cfg_req && link_up |=> cfg_cpl && cfg_cpl_data == $past(cfg_rd))
        else $error("configuration completion wrong");
    a_cfg_refused: assert property (!(cfg_req && link_up) |=> !cfg_cpl && !cfg_cpl_data)
        else $error("completion without request");
    a_msi_sent: assert property (app_intr && link_up && msi_en |=> msi_msg)
        else $error("message interrupt missing");
    a_intx_set: assert property (app_intr && link_up && !msi_en |=> intx_assert && !msi_msg)
        else $error("legacy interrupt missing");
    a_vc_code: assert property (req_vc_valid |=> vc_reject == ($past(req_vc) != pcr_pkg::VC_DEFAULT))
        else $error("channel reject wrong");
    a_vc_idle: assert property (!req_vc_valid |=> !vc_reject)
        else $error("channel reject without request");
endmodule : pcr_rc_props
bind pcr_reset_ctrl pcr_rc_props #(.LANES(LANES)) u_props (.clk_sys(clk_sys), .nrst(nrst), .core_rst(core_rst),
    .wrap_pll_lock(wrap_pll_lock), .xcvr_pll_lock(xcvr_pll_lock), .cfg_req(cfg_req), .cfg_rd(cfg_rd),
    .app_intr(app_intr), .msi_en(msi_en), .req_vc_valid(req_vc_valid), .req_vc(req_vc), .user_rst(user_rst),
    .link_state(link_state), .link_up(link_up), .cfg_cpl(cfg_cpl), .cfg_cpl_data(cfg_cpl_data),
    .msi_msg(msi_msg), .intx_assert(intx_assert), .vc_reject(vc_reject));
`default_nettype wire

// File: tb/pcr_reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_reset_ctrl_tb;
    localparam int L = pcr_pkg::LANES;
    localparam int W = pcr_pkg::WORD_W;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0, core_rst = 1'b0, wrap_pll_lock = 1'b1, train = 1'b0, hot = 1'b0, lane_rev = 1'b0;
    logic user_ready = 1'b0, cfg_req = 1'b0, cfg_rd = 1'b0, app_intr = 1'b0, msi_en = 1'b0, intx_clr = 1'b0;
    logic req_vc_valid = 1'b0;
    logic [L-1:0] xcvr_pll_lock = '1, lane_inv = '0, pol_inv;
    logic [pcr_pkg::VC_W-1:0] req_vc = '0;
    logic rx_valid, rx_ready, rx_end, rx_detected, ts_locked, hot_rst_os, user_valid, user_rst, hot_rst_rcvd;
    logic link_up, lanes_reversed, cfg_cpl, cfg_cpl_data, msi_msg, intx_assert, vc_reject;
    logic [W-1:0] rx_data, d;
    logic [pcr_pkg::LFSR_W-1:0] lf;
    logic ok;
    realtime t0;
    pcr_pkg::pcr_word_t user_word;
    pcr_pkg::pcr_link_t link_state;
    pcr_pkg::pcr_word_t expq[$];
    int error_cnt = 0, check_count = 0, got = 0, i, k, seed;
    always #50 clk_sys = ~clk_sys;
    pcr_reset_ctrl #(.HOT_CYC(3)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .core_rst(core_rst), .wrap_pll_lock(wrap_pll_lock),
        .xcvr_pll_lock(xcvr_pll_lock), .rx_detected(rx_detected), .ts_locked(ts_locked), .hot_rst_os(hot_rst_os),
        .lane_inv(lane_inv), .lane_rev(lane_rev), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_end(rx_end), .user_word(user_word), .user_valid(user_valid), .user_ready(user_ready),
        .user_rst(user_rst), .hot_rst_rcvd(hot_rst_rcvd), .link_state(link_state), .link_up(link_up),
        .pol_inv(pol_inv), .lanes_reversed(lanes_reversed), .cfg_req(cfg_req), .cfg_rd(cfg_rd),
        .cfg_cpl(cfg_cpl), .cfg_cpl_data(cfg_cpl_data), .app_intr(app_intr), .msi_en(msi_en),
        .intx_clr(intx_clr), .msi_msg(msi_msg), .intx_assert(intx_assert), .req_vc_valid(req_vc_valid),
        .req_vc(req_vc), .vc_reject(vc_reject));
    pcr_link_partner lp (.clk_sys(clk_sys), .train(train), .hot(hot), .rx_detected(rx_detected),
        .ts_locked(ts_locked), .hot_rst_os(hot_rst_os), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_end(rx_end));
    task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic wait_up(input logic v);
        int n;
        n = 0;
        while (link_up !== v && n < 400)
        begin
            cyc(1);
            n++;
        end
        check("link_up", link_up, v);
        if (link_up !== v)
            summarize();
    endtask : wait_up
    function automatic logic [pcr_pkg::LFSR_W-1:0] lfsr_next(input logic [pcr_pkg::LFSR_W-1:0] s);
        return {s[14:0], s[15] ^ s[4] ^ s[3] ^ s[2]};
    endfunction : lfsr_next
    function automatic logic [W-1:0] word_exp(input logic [W-1:0] w, input logic [pcr_pkg::LFSR_W-1:0] s);
        logic [W-1:0] r;
        for (int g = 0; g < L; g++)
            r[g*8+:8] = w[(lane_rev ? L-1-g : g)*8+:8] ^ {8{lane_inv[g]}} ^ s[7:0];
        return r;
    endfunction : word_exp
    always @(posedge clk_sys)
        if (user_valid === 1'b1 && user_ready === 1'b1 && expq.size() > 0)
        begin
            check("user_word", user_word, expq.pop_front());
            got++;
        end
    initial
    begin
        seed = $urandom(51);
        lane_inv = L'($urandom);
        lane_rev = 1'($urandom);
        cyc(2);
        nrst = 1'b1;
        train = 1'b1;
        wait_up(1'b1);
        check("link_state", link_state, pcr_pkg::PCR_L0);
        check("user_rst", user_rst, 1'b0);
        check("pol_inv", pol_inv, lane_inv);
        check("lanes_reversed", lanes_reversed, lane_rev);
        @(posedge clk_sys);
        t0 = $realtime;
        @(posedge clk_sys);
        check("clk period", int'($realtime - t0), 1_000_000_000 / pcr_pkg::CLK_HZ);
        cyc(1);
        $display("test training done");
        for (i = 0; i < 4; i++)
        begin
            cfg_req = 1'b1;
            cfg_rd = i[0];
            cyc(1);
            check("cfg_cpl", cfg_cpl, 1'b1);
            check("cfg_cpl_data", cfg_cpl_data, i[0]);
        end
        cfg_req = 1'b0;
        msi_en = 1'b1;
        app_intr = 1'b1;
        cyc(1);
        check("cfg idle", cfg_cpl, 1'b0);
        check("msi_msg", msi_msg, 1'b1);
        msi_en = 1'b0;
        intx_clr = 1'b1;
        cyc(1);
        app_intr = 1'b0;
        check("intx set", intx_assert, 1'b1);
        check("msi off", msi_msg, 1'b0);
        cyc(1);
        intx_clr = 1'b0;
        check("intx clear", intx_assert, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            req_vc_valid = 1'b1;
            req_vc = i[2:0];
            cyc(1);
            check("vc_reject", vc_reject, i != 0);
        end
        req_vc_valid = 1'b0;
        $display("test requests done");
        lf = pcr_pkg::LFSR_SEED;
        fork
            for (k = 0; k < 12; k++)
            begin
                d = W'($urandom);
                expq.push_back({word_exp(d, lf), k == 11});
                lf = lfsr_next(lf);
                lp.send(d, k == 11, ok);
                check("rx taken", ok, 1'b1);
            end
            begin
                cyc(40);
                check("rx_ready full", rx_ready, 1'b0);
                repeat (40)
                begin
                    cyc(1);
                    user_ready = 1'($urandom);
                end
                user_ready = 1'b1;
            end
        join
        cyc(10);
        check("words", got, 12);
        check("drained", user_valid, 1'b0);
        $display("test stream done");
        hot = 1'b1;
        wait_up(1'b0);
        check("hot_rst_rcvd", hot_rst_rcvd, 1'b1);
        check("user_rst hot", user_rst, 1'b0);
        hot = 1'b0;
        wait_up(1'b1);
        $display("test hot reset done");
        for (k = 0; k < 3; k++)
        begin
            core_rst = k == 0;
            wrap_pll_lock = k != 1;
            xcvr_pll_lock = (k == 2) ? ~(L'(1) << $urandom_range(L-1)) : '1;
            cyc(2);
            check("user_rst early", user_rst, 1'b0);
            cyc(1);
            check("user_rst", user_rst, 1'b1);
            check("link_state", link_state, pcr_pkg::PCR_DETECT);
            cfg_req = 1'b1;
            cyc(1);
            cfg_req = 1'b0;
            check("cfg refused", cfg_cpl, 1'b0);
            {core_rst, wrap_pll_lock, xcvr_pll_lock} = {1'b0, 1'b1, {L{1'b1}}};
            cyc(2);
            check("user_rst held", user_rst, 1'b1);
            cyc(1);
            check("user_rst free", user_rst, 1'b0);
            wait_up(1'b1);
        end
        $display("test reset causes done");
        summarize();
    end
endmodule : pcr_reset_ctrl_tb
`default_nettype wire
